// [core/timer8_pkg.sv]
// Purpose: Shared constants and types of the 8-bit waveform timer.
// Assumes: AHB-Lite register access, one 200 MHz clock.
// Notes: Register offsets are word indexes; byte address is four times the index.
package timer8_pkg;

	// ----------------------------------------------------------------
	// Register indexes
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CTRL_A = 8'h24;
	localparam logic [7:0] IDX_CTRL_B = 8'h25;
	localparam logic [7:0] IDX_COUNT = 8'h26;
	localparam logic [7:0] IDX_CMP_A = 8'h27;
	localparam logic [7:0] IDX_CMP_B = 8'h28;
	localparam logic [7:0] IDX_FLAGS = 8'h35;
	localparam logic [7:0] IDX_MASK = 8'h6E;

	// ----------------------------------------------------------------
	// Field positions and values
	// ----------------------------------------------------------------
	localparam int BIT_FORCE_A = 7;
	localparam int BIT_FORCE_B = 6;
	localparam int BIT_WAVE_HI = 3;
	localparam int BIT_WRAP = 0;
	localparam int BIT_MATCH_A = 1;
	localparam int BIT_MATCH_B = 2;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] COUNT_ONE = 8'h01;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// Waveform modes
	localparam logic [2:0] WM_NORMAL = 3'h0;
	localparam logic [2:0] WM_PHASE_FF = 3'h1;
	localparam logic [2:0] WM_CTC = 3'h2;
	localparam logic [2:0] WM_FAST_FF = 3'h3;
	localparam logic [2:0] WM_PHASE_A = 3'h5;
	localparam logic [2:0] WM_FAST_A = 3'h7;

	// Clock select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// Prescaler tap masks
	localparam logic [9:0] PRE_MASK_8 = 10'h007;
	localparam logic [9:0] PRE_MASK_64 = 10'h03F;
	localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
	localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

	// Compare output modes
	localparam logic [1:0] OM_OFF = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR = 2'h2;
	localparam logic [1:0] OM_SET = 2'h3;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

	typedef struct packed {
		logic pwm_fast;
		logic pwm_phase;
		logic ctc;
		logic reserved;
		logic top_is_a;
	} mode_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] index;
	} bus_req_t;

	function automatic mode_t decode_mode(input logic [2:0] wm);
		mode_t m;
		m = '0;
		m.pwm_fast = (wm == WM_FAST_FF) || (wm == WM_FAST_A);
		m.pwm_phase = (wm == WM_PHASE_FF) || (wm == WM_PHASE_A);
		m.ctc = (wm == WM_CTC);
		m.reserved = !(m.pwm_fast || m.pwm_phase || m.ctc || (wm == WM_NORMAL));
		m.top_is_a = (wm == WM_CTC) || (wm == WM_PHASE_A) || (wm == WM_FAST_A);
		return m;
	endfunction

endpackage

// [core/timer_tick_gen.sv]
// Purpose: Timer clock enable from prescaler taps or the external count pin.
// Assumes: Pin is asynchronous to hclk.
// Notes: Prescaler runs freely; tick is a one-cycle enable.
`timescale 1ns/10ps
module timer_tick_gen
	import timer8_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [2:0] clk_sel,
	input wire logic ext_count_pin,
	output logic tick
);

	logic [9:0] pre_reg;
	logic sync1_reg;
	logic sync2_reg;
	logic last_reg;

	function automatic logic tap(input logic [9:0] cnt, input logic [9:0] mask);
		return (cnt & mask) == mask;
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + 10'h001;
		end
	end

	// Pin sampled even when driven as an output, so software can step the count
	always_ff @(posedge hclk or negedge hresetn) begin // [R9] [R21]
		if (!hresetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			sync1_reg <= ext_count_pin;
			sync2_reg <= sync1_reg;
			last_reg <= sync2_reg;
		end
	end

	always_comb begin // [R8]
		unique case (clk_sel)
			CS_STOP: tick = 1'b0;
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = tap(pre_reg, PRE_MASK_8);
			CS_DIV64: tick = tap(pre_reg, PRE_MASK_64);
			CS_DIV256: tick = tap(pre_reg, PRE_MASK_256);
			CS_DIV1024: tick = tap(pre_reg, PRE_MASK_1024);
			CS_EXT_FALL: tick = last_reg && !sync2_reg;
			CS_EXT_RISE: tick = !last_reg && sync2_reg;
		endcase
	end

endmodule // timer_tick_gen

// [core/wave_channel.sv]
// Purpose: Waveform output of one compare channel.
// Assumes: match already gated by tick and counter-write blocking.
// Notes: ALLOW_PWM_TOGGLE enables toggle mode in PWM when top is channel A.
`timescale 1ns/10ps
module wave_channel
	import timer8_pkg::*;
#(
	parameter bit ALLOW_PWM_TOGGLE = 1'b0
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire mode_t mode,
	input wire logic [1:0] out_mode,
	input wire logic match,
	input wire logic force_match,
	input wire logic at_bottom,
	input wire dir_t dir,
	output logic wave_out,
	output logic wave_drive
);

	logic wave_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wave_reg <= 1'b0;
		end else if (mode.reserved) begin
			wave_reg <= wave_reg; // [R20]
		end else if (mode.pwm_fast) begin
			if (match && out_mode == OM_TOGGLE && ALLOW_PWM_TOGGLE && mode.top_is_a) begin
				wave_reg <= !wave_reg;
			end else if (match && out_mode[1]) begin
				wave_reg <= out_mode[0];
			end else if (at_bottom && out_mode[1]) begin
				wave_reg <= !out_mode[0];
			end
		end else if (mode.pwm_phase) begin
			if (match && out_mode == OM_TOGGLE && ALLOW_PWM_TOGGLE && mode.top_is_a) begin
				wave_reg <= !wave_reg;
			end else if (match && out_mode[1]) begin
				wave_reg <= (dir == DIR_UP) ? out_mode[0] : !out_mode[0];
			end
		end else if (match || force_match) begin // [R4] [R18]
			unique case (out_mode)
				OM_OFF: wave_reg <= wave_reg;
				OM_TOGGLE: wave_reg <= !wave_reg;
				OM_CLEAR: wave_reg <= 1'b0;
				OM_SET: wave_reg <= 1'b1;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wave_out <= 1'b0;
			wave_drive <= 1'b0;
		end else begin
			wave_out <= wave_reg;
			wave_drive <= (out_mode != OM_OFF);
		end
	end

endmodule // wave_channel

// [core/timer8_core.sv]
// Purpose: 8-bit timer/counter with waveform modes, two compare channels and flags.
// Assumes: AHB-Lite slave, single word transfers, hclk 200 MHz, async active-low reset.
// Notes: Register data sit in bits 7:0; upper bits read zero; no wait states.
//
// Overview of operation
// R1: Decode three-bit waveform mode and its top
// R2: Compare update immediate, at top, or bottom
// R3: Overflow flag at max, bottom or top
// R4: Force strobe applies immediate match, non-PWM only
// R5: Forced match sets no flag, no clear
// R6: Force bits are write-only, read zero
// R7: Software writes force zero in PWM modes
// R8: Three-bit clock select, prescaler or pin edges
// R9: Pin edges counted even when pin drives
// R10: Counter is readable and writable
// R11: Counter write blocks next compare match
// R12: Compare both channels each timer clock
// R13: Match sets the channel's compare flag
// R14: Request needs mask, flag and global enable
// R15: Vector entry clears its flag
// R16: Writing one clears a flag
// R17: Unused control, mask, flag bits read zero
// R18: Non-PWM out modes: off, toggle, clear, set
// R19: Mode low bits in control A, reset zero
// R20: Reserved modes count normally, no waveform
// R21: Count only on tick; pin sampled synchronously
`timescale 1ns/10ps
module timer8_core
	import timer8_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ext_count_pin,
	input wire logic global_irq_en,
	input wire logic wrap_vector_ack,
	input wire logic match_a_vector_ack,
	input wire logic match_b_vector_ack,
	output logic wrap_irq,
	output logic match_a_irq,
	output logic match_b_irq,
	output logic wave_out_a,
	output logic wave_out_a_en,
	output logic wave_out_b,
	output logic wave_out_b_en
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	bus_req_t req_reg;
	logic [1:0] out_mode_a;
	logic [1:0] out_mode_b;
	logic [2:0] wave_mode_reg;
	logic [2:0] clk_sel_reg;
	logic [7:0] count_reg;
	logic [7:0] cmp_a_buf_reg;
	logic [7:0] cmp_b_buf_reg;
	logic [7:0] cmp_a_reg;
	logic [7:0] cmp_b_reg;
	logic [2:0] mask_reg;
	logic [2:0] flags_reg;
	logic block_reg;
	logic force_a_reg;
	logic force_b_reg;
	dir_t dir_reg;

	logic addr_ok;
	logic take;
	logic wr_en;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;
	logic tick;
	mode_t mode;
	logic [7:0] top;
	logic at_top;
	logic at_bottom;
	logic wrap_set;
	logic match_a;
	logic match_b;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;
	logic load_cmp;
	logic [7:0] count_next;
	dir_t dir_next;

	function automatic logic is_write(input bus_req_t r, input logic [7:0] idx);
		return r.valid && r.write && (r.index == idx);
	endfunction

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	assign addr_ok = (haddr[31:10] == '0) && (haddr[1:0] == 2'h0);
	assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign wr_en = req_reg.valid && req_reg.write;
	assign wbyte = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_reg <= '0;
		end else if (hready) begin
			req_reg.valid <= take && addr_ok;
			req_reg.write <= hwrite;
			req_reg.index <= haddr[9:2];
		end
	end

	// No wait states; every answer is OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end
	end

	always_comb begin
		rd_byte = RESET_BYTE;
		unique case (haddr[9:2])
			IDX_CTRL_A: rd_byte = {out_mode_a, out_mode_b, 2'b00, wave_mode_reg[1:0]}; // [R19]
			IDX_CTRL_B: rd_byte = {2'b00, 2'b00, wave_mode_reg[2], clk_sel_reg}; // [R6] [R17]
			IDX_COUNT: rd_byte = count_reg;
			IDX_CMP_A: rd_byte = cmp_a_buf_reg;
			IDX_CMP_B: rd_byte = cmp_b_buf_reg;
			IDX_MASK: rd_byte = {5'b00000, mask_reg}; // [R17]
			IDX_FLAGS: rd_byte = {5'b00000, flags_reg}; // [R17]
			default: rd_byte = RESET_BYTE;
		endcase
	end

	// Read data captured at the end of the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= WORD_ZERO;
		end else if (take && !hwrite && addr_ok) begin
			hrdata <= {24'h000000, rd_byte};
		end else if (hready) begin
			hrdata <= WORD_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_mode_a <= OM_OFF;
			out_mode_b <= OM_OFF;
			wave_mode_reg <= WM_NORMAL;
			clk_sel_reg <= CS_STOP;
		end else begin
			if (is_write(req_reg, IDX_CTRL_A)) begin
				out_mode_a <= wbyte[7:6];
				out_mode_b <= wbyte[5:4];
				wave_mode_reg[1:0] <= wbyte[1:0]; // [R19]
			end
			if (is_write(req_reg, IDX_CTRL_B)) begin
				wave_mode_reg[2] <= wbyte[BIT_WAVE_HI];
				clk_sel_reg <= wbyte[2:0]; // [R8]
			end
		end
	end

	// Force strobes last one cycle and never store
	always_ff @(posedge hclk or negedge hresetn) begin // [R6]
		if (!hresetn) begin
			force_a_reg <= 1'b0;
			force_b_reg <= 1'b0;
		end else begin
			force_a_reg <= is_write(req_reg, IDX_CTRL_B) && wbyte[BIT_FORCE_A];
			force_b_reg <= is_write(req_reg, IDX_CTRL_B) && wbyte[BIT_FORCE_B];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_reg <= '0;
		end else if (is_write(req_reg, IDX_MASK)) begin
			mask_reg <= wbyte[2:0]; // [R17]
		end
	end

	// ----------------------------------------------------------------
	// Timer clock
	// ----------------------------------------------------------------
	timer_tick_gen u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_sel(clk_sel_reg),
		.ext_count_pin(ext_count_pin),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// Mode decode and counter
	// ----------------------------------------------------------------
	assign mode = decode_mode(wave_mode_reg); // [R1] [R20]
	assign top = mode.top_is_a ? cmp_a_reg : COUNT_MAX; // [R1]
	assign at_top = (count_reg == top);
	assign at_bottom = (count_reg == COUNT_BOTTOM);

	always_comb begin // [R21]
		count_next = count_reg;
		dir_next = dir_reg;
		if (mode.pwm_phase) begin
			if (dir_reg == DIR_UP) begin
				if (at_top) begin
					dir_next = DIR_DOWN;
					count_next = count_reg - COUNT_ONE;
				end else begin
					count_next = count_reg + COUNT_ONE;
				end
			end else begin
				if (at_bottom) begin
					dir_next = DIR_UP;
					count_next = count_reg + COUNT_ONE;
				end else begin
					count_next = count_reg - COUNT_ONE;
				end
			end
		end else begin
			dir_next = DIR_UP;
			// Clear at top; a forced match never reaches this path [R5]
			count_next = (at_top && (mode.ctc || mode.pwm_fast)) ? COUNT_BOTTOM : count_reg + COUNT_ONE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= RESET_BYTE;
			dir_reg <= DIR_UP;
		end else if (is_write(req_reg, IDX_COUNT)) begin
			count_reg <= wbyte; // [R10]
		end else if (tick) begin
			count_reg <= count_next; // [R21]
			dir_reg <= dir_next;
		end
	end

	// Blocks the match on the next tick after a counter write
	always_ff @(posedge hclk or negedge hresetn) begin // [R11]
		if (!hresetn) begin
			block_reg <= 1'b0;
		end else if (is_write(req_reg, IDX_COUNT)) begin
			block_reg <= 1'b1;
		end else if (tick) begin
			block_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Compare registers, double buffered in PWM modes
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_a_buf_reg <= RESET_BYTE;
			cmp_b_buf_reg <= RESET_BYTE;
		end else begin
			if (is_write(req_reg, IDX_CMP_A)) begin
				cmp_a_buf_reg <= wbyte;
			end
			if (is_write(req_reg, IDX_CMP_B)) begin
				cmp_b_buf_reg <= wbyte;
			end
		end
	end

	// Phase modes load at top, fast modes at bottom, others at once
	assign load_cmp = (!mode.pwm_phase && !mode.pwm_fast) ||
		(mode.pwm_phase && tick && at_top && dir_reg == DIR_UP) ||
		(mode.pwm_fast && tick && at_top); // [R2]

	always_ff @(posedge hclk or negedge hresetn) begin // [R2]
		if (!hresetn) begin
			cmp_a_reg <= RESET_BYTE;
			cmp_b_reg <= RESET_BYTE;
		end else if (load_cmp) begin
			cmp_a_reg <= cmp_a_buf_reg;
			cmp_b_reg <= cmp_b_buf_reg;
		end
	end

	// ----------------------------------------------------------------
	// Match and overflow events
	// ----------------------------------------------------------------
	assign match_a = tick && !block_reg && (count_reg == cmp_a_reg); // [R11] [R12]
	assign match_b = tick && !block_reg && (count_reg == cmp_b_reg); // [R11] [R12]

	always_comb begin // [R3]
		wrap_set = 1'b0;
		if (tick) begin
			if (mode.pwm_phase) begin
				wrap_set = at_bottom && (dir_reg == DIR_DOWN);
			end else if (wave_mode_reg == WM_FAST_A) begin
				wrap_set = at_top;
			end else begin
				wrap_set = (count_reg == COUNT_MAX);
			end
		end
	end

	// ----------------------------------------------------------------
	// Flags and requests
	// ----------------------------------------------------------------
	assign flag_set = {match_b, match_a, wrap_set}; // [R5] [R13]
	assign flag_clr = ({3{is_write(req_reg, IDX_FLAGS)}} & wbyte[2:0]) |
		{match_b_vector_ack, match_a_vector_ack, wrap_vector_ack}; // [R15] [R16]

	// A set in the same cycle as a clear wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= (flags_reg & ~flag_clr) | flag_set; // [R13] [R16]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin // [R14]
		if (!hresetn) begin
			wrap_irq <= 1'b0;
			match_a_irq <= 1'b0;
			match_b_irq <= 1'b0;
		end else begin
			wrap_irq <= global_irq_en && mask_reg[BIT_WRAP] && flags_reg[BIT_WRAP];
			match_a_irq <= global_irq_en && mask_reg[BIT_MATCH_A] && flags_reg[BIT_MATCH_A];
			match_b_irq <= global_irq_en && mask_reg[BIT_MATCH_B] && flags_reg[BIT_MATCH_B];
		end
	end

	// ----------------------------------------------------------------
	// Waveform outputs
	// ----------------------------------------------------------------
	// Force is ignored in PWM modes, so a stray one written there has no effect [R7]
	wave_channel #(.ALLOW_PWM_TOGGLE(1'b1)) u_wave_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.mode(mode),
		.out_mode(out_mode_a),
		.match(match_a),
		.force_match(force_a_reg), // [R4]
		.at_bottom(tick && at_top && mode.pwm_fast),
		.dir(dir_reg),
		.wave_out(wave_out_a),
		.wave_drive(wave_out_a_en)
	);

	wave_channel #(.ALLOW_PWM_TOGGLE(1'b0)) u_wave_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.mode(mode),
		.out_mode(out_mode_b),
		.match(match_b),
		.force_match(force_b_reg), // [R4]
		.at_bottom(tick && at_top && mode.pwm_fast),
		.dir(dir_reg),
		.wave_out(wave_out_b),
		.wave_drive(wave_out_b_en)
	);

endmodule // timer8_core

// [tb/timer8_core_props.sv]
// Purpose: Bus and interrupt properties of the 8-bit timer core.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Sees only the core's ports; bound below.
`timescale 1ns/10ps
module timer8_core_props
	import timer8_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic global_irq_en,
	input wire logic wrap_irq,
	input wire logic match_a_irq,
	input wire logic match_b_irq,
	input wire logic wave_out_a_en
);
	logic req;
	logic rd_req;
	logic [7:0] idx;
	assign req = hsel && hready && (htrans == HTRANS_NONSEQ) && (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);
	assign rd_req = req && !hwrite;
	assign idx = haddr[9:2];

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_resp_okay: assert property (hreadyout && (hresp == HRESP_OKAY))
		else $error("slave not ready or not OKAY");
	chk_rdata_idle: assert property (!rd_req |=> hrdata == WORD_ZERO)
		else $error("read data outside a read");
	chk_force_rd_zero: assert property (rd_req && idx == IDX_CTRL_B |=> hrdata[7:4] == 4'h0)
		else $error("force or spare bits of control B read nonzero");
	chk_spare_rd_zero: assert property (rd_req && (idx == IDX_MASK || idx == IDX_FLAGS) |=> hrdata[7:3] == 5'h00)
		else $error("spare mask or flag bits read nonzero");
	chk_ctrla_rd_zero: assert property (rd_req && idx == IDX_CTRL_A |=> hrdata[3:2] == 2'h0)
		else $error("spare control A bits read nonzero");
	chk_wrap_irq_gate: assert property (!global_irq_en |=> !wrap_irq)
		else $error("wrap request without global enable");
	chk_match_a_gate: assert property (match_a_irq |-> $past(global_irq_en))
		else $error("match A request without global enable");
	chk_match_b_gate: assert property ($rose(match_b_irq) |-> $past(global_irq_en))
		else $error("match B request without global enable");
	chk_out_en_a: assert property (req && hwrite && idx == IDX_CTRL_A ##1 hwdata[7:6] != OM_OFF
		|-> ##[1:3] wave_out_a_en)
		else $error("channel A output not enabled");

	cover property (wrap_irq);
	cover property (match_a_irq && match_b_irq);
	cover property (rd_req && idx == IDX_FLAGS);
endmodule // timer8_core_props

bind timer8_core timer8_core_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .global_irq_en(global_irq_en), .wrap_irq(wrap_irq), .match_a_irq(match_a_irq),
	.match_b_irq(match_b_irq), .wave_out_a_en(wave_out_a_en));

// [tb/timer8_cpu_model.sv]
// Purpose: Processor side of the timer: AHB-Lite master and vector entry.
// Assumes: Zero-wait slave is not assumed; waits on hready.
// Notes: Write data is inverted in each address phase, before the new data phase.
`timescale 1ns/10ps
module timer8_cpu_model
	import timer8_pkg::*;
(
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	output logic wrap_vector_ack,
	output logic match_a_vector_ack,
	output logic match_b_vector_ack
);
	logic [1:0] mode_lo;
	initial begin
		mode_lo = 2'h0;
		hsel = 1'b0;
		haddr = WORD_ZERO;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = WORD_ZERO;
		wrap_vector_ack = 1'b0;
		match_a_vector_ack = 1'b0;
		match_b_vector_ack = 1'b0;
	end

	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		logic [7:0] d;
		d = wd;
		if (wr && idx == IDX_CTRL_A) begin
			mode_lo = wd[1:0];
		end
		// Odd mode codes are the PWM modes, where force bits must go out as zero
		if (wr && idx == IDX_CTRL_B && mode_lo[0]) begin
			d[7:6] = 2'h0;
		end
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hwdata <= ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata[7:0];
		hsel <= 1'b0;
	endtask

	task automatic pulse_wrap();
		@(posedge hclk);
		wrap_vector_ack <= 1'b1;
		@(posedge hclk);
		wrap_vector_ack <= 1'b0;
	endtask
endmodule // timer8_cpu_model

// [tb/test_eight_bit_timer_waveform_core.sv]
// Purpose: Self-checking bench of the 8-bit waveform timer core.
// Assumes: 200 MHz hclk, processor model as bus master.
// Notes: Clock windows are short so counts stay far from unwanted matches.
`timescale 1ns/10ps
module test_eight_bit_timer_waveform_core
	import timer8_pkg::*;
;
	typedef struct packed {
		logic wr;
		logic [7:0] idx;
		logic [7:0] wd;
		logic [7:0] exp;
	} row_t;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_count_pin, global_irq_en;
	logic wrap_vector_ack, match_a_vector_ack, match_b_vector_ack, wrap_irq, match_a_irq, match_b_irq;
	logic wave_out_a, wave_out_a_en, wave_out_b, wave_out_b_en;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	row_t rows [14];
	logic [1:0] oms [4];
	logic [3:0] exps;
	int mismatches = 0;
	int n_checks = 0;

	timer8_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_count_pin(ext_count_pin), .global_irq_en(global_irq_en),
		.wrap_vector_ack(wrap_vector_ack), .match_a_vector_ack(match_a_vector_ack),
		.match_b_vector_ack(match_b_vector_ack), .wrap_irq(wrap_irq), .match_a_irq(match_a_irq),
		.match_b_irq(match_b_irq), .wave_out_a(wave_out_a), .wave_out_a_en(wave_out_a_en),
		.wave_out_b(wave_out_b), .wave_out_b_en(wave_out_b_en));
	timer8_cpu_model u_cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .wrap_vector_ack(wrap_vector_ack),
		.match_a_vector_ack(match_a_vector_ack), .match_b_vector_ack(match_b_vector_ack));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] x;
		u_cpu.xfer(1'b1, idx, d, x);
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] x;
		u_cpu.xfer(1'b0, idx, 8'h00, x);
		check8(x, exp);
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		final_report();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		ext_count_pin = 1'b0;
		global_irq_en = 1'b0;
		rows = '{'{1'b0, IDX_CTRL_A, 8'h00, 8'h00}, '{1'b0, IDX_CTRL_B, 8'h00, 8'h00},
			'{1'b0, IDX_CMP_B, 8'h00, 8'h00}, '{1'b0, IDX_MASK, 8'h00, 8'h00},
			'{1'b1, IDX_CTRL_B, 8'hC8, 8'h08}, '{1'b1, IDX_CTRL_B, 8'h00, 8'h00},
			'{1'b1, IDX_CTRL_A, 8'hFF, 8'hF3}, '{1'b1, IDX_CTRL_A, 8'h00, 8'h00},
			'{1'b1, IDX_MASK, 8'hFF, 8'h07}, '{1'b1, IDX_CMP_B, 8'h5A, 8'h5A},
			'{1'b1, IDX_CMP_A, 8'hA5, 8'hA5}, '{1'b1, IDX_COUNT, 8'h3C, 8'h3C},
			'{1'b1, IDX_FLAGS, 8'h00, 8'h00}, '{1'b1, 8'h30, 8'h5A, 8'h00}};
		oms = '{OM_TOGGLE, OM_TOGGLE, OM_SET, OM_CLEAR};
		exps = 4'b0101;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		global_irq_en <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].idx, rows[i].wd);
			end
			rdchk(rows[i].idx, rows[i].exp);
		end
		$display("register table done");
		wr(IDX_COUNT, 8'hFE);
		wr(IDX_CTRL_B, {5'h00, CS_DIV1});
		wr(IDX_CTRL_B, 8'h00);
		rdchk(IDX_FLAGS, 8'h01);
		check8({7'h0, wrap_irq}, 8'h01);
		wr(IDX_FLAGS, 8'h00);
		rdchk(IDX_FLAGS, 8'h01);
		u_cpu.pulse_wrap();
		rdchk(IDX_FLAGS, 8'h00);
		repeat (3) @(posedge hclk);
		check8({7'h0, wrap_irq}, 8'h00);
		$display("overflow test done");
		wr(IDX_CMP_A, 8'h10);
		wr(IDX_CMP_B, 8'h0F);
		wr(IDX_COUNT, 8'h0E);
		wr(IDX_CTRL_B, {5'h00, CS_DIV1});
		rdchk(IDX_MASK, 8'h07);
		wr(IDX_CTRL_B, 8'h00);
		rdchk(IDX_FLAGS, 8'h06);
		check8({6'h0, match_b_irq, match_a_irq}, 8'h03);
		global_irq_en <= 1'b0;
		repeat (2) @(posedge hclk);
		check8({6'h0, match_b_irq, match_a_irq}, 8'h00);
		global_irq_en <= 1'b1;
		wr(IDX_FLAGS, 8'h02);
		rdchk(IDX_FLAGS, 8'h04);
		wr(IDX_FLAGS, 8'h04);
		rdchk(IDX_FLAGS, 8'h00);
		$display("compare test done");
		wr(IDX_CMP_A, 8'h20);
		wr(IDX_CMP_B, 8'h30);
		wr(IDX_COUNT, 8'h20);
		wr(IDX_CTRL_B, {5'h00, CS_DIV1});
		wr(IDX_CTRL_B, 8'h00);
		rdchk(IDX_FLAGS, 8'h00);
		$display("write block test done");
		for (int i = 0; i < 2; i++) begin
			wr(IDX_COUNT, 8'h00);
			wr(IDX_CTRL_B, {5'h00, (i == 0) ? CS_EXT_FALL : CS_EXT_RISE});
			repeat (3) begin
				@(posedge hclk);
				ext_count_pin <= 1'b1;
				repeat (4) @(posedge hclk);
				ext_count_pin <= 1'b0;
				repeat (4) @(posedge hclk);
			end
			repeat (6) @(posedge hclk);
			wr(IDX_CTRL_B, 8'h00);
			rdchk(IDX_COUNT, 8'h03);
		end
		$display("pin clock test done");
		for (int i = 0; i < 4; i++) begin
			wr(IDX_CTRL_A, {oms[i], 6'h00});
			wr(IDX_CTRL_B, 8'h80);
			repeat (5) @(posedge hclk);
			check8({7'h0, wave_out_a}, {7'h0, exps[i]});
		end
		check8({7'h0, wave_out_a_en}, 8'h01);
		rdchk(IDX_FLAGS, 8'h00);
		rdchk(IDX_COUNT, 8'h03);
		wr(IDX_CTRL_A, 8'h30);
		wr(IDX_CTRL_B, 8'h40);
		repeat (5) @(posedge hclk);
		check8({5'h0, wave_out_b_en, wave_out_b, wave_out_a_en}, 8'h06);
		wr(IDX_CMP_A, 8'h01);
		wr(IDX_COUNT, 8'h00);
		wr(IDX_CTRL_A, 8'h02);
		wr(IDX_CTRL_B, {5'h00, CS_DIV1});
		wr(IDX_CTRL_B, 8'h00);
		rdchk(IDX_COUNT, 8'h01);
		$display("force test done");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk(IDX_CTRL_A, 8'h00);
		$display("reset test done");
		final_report();
	end
endmodule // test_eight_bit_timer_waveform_core
